// ### common/twowire_pkg.sv
// Shared constants and types for the two-wire bus control, rate and data block
package twowire_pkg;
  // Control flags, most significant bit first
  typedef struct packed {
    logic busy;
    logic enable;
    logic start_request_flag;
    logic stop_request_flag;
    logic serial_irq_flag;
    logic acknowledge_assert_flag;
    logic free_timer_enable;
    logic low_timeout_enable;
  } ctrl_flags_t;

  // Open-drain drive enables for the two bus lines
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } line_drive_t;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Status codes; all but idle are reported with the serial interrupt flag
  localparam logic [7:0] ST_IDLE = 8'hf8;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RESTART = 8'h10;
  localparam logic [7:0] ST_ADDR_W_ACK = 8'h18;
  localparam logic [7:0] ST_ADDR_W_NACK = 8'h20;
  localparam logic [7:0] ST_TX_ACK = 8'h28;
  localparam logic [7:0] ST_TX_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_ADDR_R_ACK = 8'h40;
  localparam logic [7:0] ST_ADDR_R_NACK = 8'h48;
  localparam logic [7:0] ST_RX_ACK = 8'h50;
  localparam logic [7:0] ST_RX_NACK = 8'h58;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int HIGH_EXTRA_NS = 625;
  localparam int HIGH_BASE_EXTRA_CYC = 2;
  localparam int HIGH_PAD_CYC = HIGH_BASE_EXTRA_CYC + HIGH_EXTRA_NS / CLK_PERIOD_NS;
  localparam logic [3:0] FREE_OVERFLOWS = 4'ha;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// ### design/rate_counter.sv
// Up counter preloaded from the clock-rate setting, flags overflow at all ones
`timescale 1ns/1ps
module rate_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] preload,
  input wire logic count_en,
  output logic overflow
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;

  // Overflow is the last cycle of a period of (2^WIDTH - preload) cycles
  assign overflow = count_en && (cnt == {WIDTH{1'b1}});

  // Next count
  always_comb
  begin
    next_cnt = cnt;
    if (load)
    begin
      next_cnt = preload;
    end
    else if (count_en)
    begin
      // Reload at overflow so every period is short, not only the first
      next_cnt = overflow ? preload : cnt + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end
endmodule

// ### design/data_shift_reg.sv
// Shift data register: parallel load from software, MSB-first shift with serial input
`timescale 1ns/1ps
module data_shift_reg #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic shift_en,
  input wire logic shift_in,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] next_q;

  // Load wins; software only writes while the transfer is suspended
  always_comb
  begin
    next_q = q;
    if (load)
    begin
      next_q = load_data;
    end
    else if (shift_en)
    begin
      next_q = {q[WIDTH-2:0], shift_in};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= twowire_pkg::DATA_RESET;
    end
    else
    begin
      q <= next_q;
    end
  end
endmodule

// ### design/twowire_bus_ctrl_rate_data.sv
// Two-wire bus control flags, clock-rate timing, master byte engine and data shifting
`timescale 1ns/1ps
// Behaviour
// - Interrupt flag set on any reportable state entry, never for idle; software clears.
// - In the acknowledge bit of a received byte drive SDA low when acknowledge flag set, else release.
// - Master SCL low time is 256 minus rate setting clock periods.
// - Master SCL high time is 258 minus rate setting periods plus 625 ns.
// - Bus-free timeout is ten rate-counter periods plus one cycle.
// - Transmitted bytes leave MSB first.
// - First received bit ends up in the data register MSB.
// - Bus level is shifted in while shifting out, so data holds last bus byte.
// - On arbitration loss become slave receiver with data register still correct.
// - Start flag enters master mode; START when free, repeated START after bytes.
// - Stop flag makes master send STOP; hardware clears it on detected STOP.
// - With free timer enabled, rate counter runs while SCL high; tenth overflow frees bus.
// - With low timeout enabled, external timer reloads on SCL high, counts on low.
module twowire_bus_ctrl_rate_data (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic rate_wr,
  input wire logic [7:0] rate_wdata,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] ctrl_rdata,
  output logic [7:0] rate_rdata,
  output logic [7:0] data_rdata,
  output logic [7:0] status_code,
  input wire logic ext_state_valid,
  input wire logic [7:0] ext_state_code,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic timer_reload,
  output logic timer_count
);
  typedef enum logic [3:0] {
    S_IDLE, S_START_HOLD, S_BIT_LOW, S_BIT_HIGH, S_SUSPEND,
    S_STOP_LOW, S_STOP_HIGH, S_RESTART_LOW, S_RESTART_HIGH, S_SLAVE_RX
  } eng_state_t;

  eng_state_t state, next_state;
  twowire_pkg::ctrl_flags_t ctrl, next_ctrl, wr_flags;
  twowire_pkg::line_drive_t drive, next_drive;
  logic [7:0] rate, next_rate;
  logic [7:0] next_status;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [6:0] pad_cnt, next_pad_cnt;
  logic pad_run, next_pad_run;
  logic master, next_master;
  logic first_byte, next_first_byte;
  logic rx_dir, next_rx_dir;
  logic ack_seen, next_ack_seen;
  logic [3:0] free_cnt, next_free_cnt;
  logic next_timer_reload, next_timer_count;
  logic scl_meta, scl_s, scl_q, sda_meta, sda_s, sda_q;
  logic scl_rise, start_seen, stop_seen, free_timeout;
  logic high_phase, low_phase, high_done, low_done;
  logic tmr_load, tmr_en, tmr_ovf, free_run, free_ovf;
  logic sh_shift, transmitting, lose, report;
  logic [7:0] sh_q;
  logic [7:0] byte_code;

  assign wr_flags = ctrl_wdata;
  assign ctrl_rdata = ctrl;
  assign rate_rdata = rate;
  assign data_rdata = sh_q;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = drive.scl_oe;
  assign sda_oe = drive.sda_oe;

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_meta <= scl_in;
      scl_s <= scl_meta;
      scl_q <= scl_s;
      sda_meta <= sda_in;
      sda_s <= sda_meta;
      sda_q <= sda_s;
    end
  end

  // Bus condition detectors on the synchronised lines
  assign scl_rise = scl_s && !scl_q;
  assign start_seen = scl_s && scl_q && sda_q && !sda_s;
  assign stop_seen = scl_s && scl_q && !sda_q && sda_s;
  assign transmitting = first_byte || !rx_dir;

  // SCL phase timing shared by all low and high phases
  assign high_phase = (state == S_START_HOLD) || (state == S_BIT_HIGH) ||
                      (state == S_STOP_HIGH) || (state == S_RESTART_HIGH);
  assign low_phase = (state == S_BIT_LOW) || (state == S_STOP_LOW) ||
                     (state == S_RESTART_LOW);
  assign low_done = low_phase && tmr_ovf;
  assign high_done = high_phase && pad_run && (pad_cnt == 7'(twowire_pkg::HIGH_PAD_CYC - 1));

  // High time only starts once SCL is really high, so stretching by others is honoured
  always_comb
  begin
    tmr_en = low_phase || (high_phase && scl_s && !pad_run);
    tmr_load = (next_state != state) || (high_phase && !scl_s);
    next_pad_run = pad_run;
    next_pad_cnt = pad_cnt;
    if (next_state != state)
    begin
      next_pad_run = 1'b0;
      next_pad_cnt = '0;
    end
    else if (high_phase && tmr_ovf)
    begin
      next_pad_run = 1'b1;
    end
    else if (pad_run)
    begin
      next_pad_cnt = pad_cnt + 1'b1;
    end
  end

  rate_counter #(.WIDTH(8)) u_phase_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .preload(rate),
    .count_en(tmr_en),
    .overflow(tmr_ovf)
  );

  // Free timer runs only while the bus is held busy with SCL high
  assign free_run = ctrl.enable && ctrl.busy && ctrl.free_timer_enable && scl_s;
  assign free_timeout = (free_cnt == twowire_pkg::FREE_OVERFLOWS);

  rate_counter #(.WIDTH(8)) u_free_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(!free_run || free_timeout),
    .preload(rate),
    .count_en(free_run && !free_timeout),
    .overflow(free_ovf)
  );

  data_shift_reg #(.WIDTH(8)) u_data (
    .clk(clk),
    .rst_n(rst_n),
    .load(data_wr),
    .load_data(data_wdata),
    .shift_en(sh_shift),
    .shift_in(sda_s),
    .q(sh_q)
  );

  // Status code for a finished byte, from direction and sampled acknowledge
  always_comb
  begin
    if (first_byte)
    begin
      if (sh_q[0])
      begin
        byte_code = ack_seen ? twowire_pkg::ST_ADDR_R_ACK : twowire_pkg::ST_ADDR_R_NACK;
      end
      else
      begin
        byte_code = ack_seen ? twowire_pkg::ST_ADDR_W_ACK : twowire_pkg::ST_ADDR_W_NACK;
      end
    end
    else if (rx_dir)
    begin
      byte_code = ack_seen ? twowire_pkg::ST_RX_ACK : twowire_pkg::ST_RX_NACK;
    end
    else
    begin
      byte_code = ack_seen ? twowire_pkg::ST_TX_ACK : twowire_pkg::ST_TX_NACK;
    end
  end

  // Engine, flags and register next values
  always_comb
  begin
    next_state = state;
    next_ctrl = ctrl;
    next_rate = rate_wr ? rate_wdata : rate;
    next_status = status_code;
    next_bit_cnt = bit_cnt;
    next_master = master;
    next_first_byte = first_byte;
    next_rx_dir = rx_dir;
    next_ack_seen = ack_seen;
    next_drive = drive;
    next_free_cnt = free_ovf ? free_cnt + 1'b1 : free_cnt;
    sh_shift = 1'b0;
    lose = 1'b0;
    report = 1'b0;
    if (free_timeout || !free_run)
    begin
      next_free_cnt = '0;
    end
    case (state)
      S_IDLE:
      begin
        next_drive = '0;
        if (ctrl.enable && ctrl.start_request_flag && !ctrl.busy)
        begin
          next_drive.sda_oe = 1'b1;
          next_state = S_START_HOLD;
        end
      end
      S_START_HOLD:
      begin
        if (high_done)
        begin
          next_drive.scl_oe = 1'b1;
          next_status = master ? twowire_pkg::ST_RESTART : twowire_pkg::ST_START;
          report = 1'b1;
          next_master = 1'b1;
          next_first_byte = 1'b1;
          next_bit_cnt = '0;
          next_state = S_SUSPEND;
        end
      end
      S_BIT_LOW:
      begin
        next_drive.scl_oe = 1'b1;
        if (bit_cnt < twowire_pkg::BITS_PER_BYTE)
        begin
          next_drive.sda_oe = transmitting && !sh_q[7];
        end
        else
        begin
          next_drive.sda_oe = !transmitting && ctrl.acknowledge_assert_flag;
        end
        if (low_done)
        begin
          next_state = S_BIT_HIGH;
        end
      end
      S_BIT_HIGH:
      begin
        next_drive.scl_oe = 1'b0;
        if (scl_rise && bit_cnt < twowire_pkg::BITS_PER_BYTE)
        begin
          sh_shift = 1'b1;
          lose = transmitting && !drive.sda_oe && !sda_s;
        end
        else if (scl_rise)
        begin
          next_ack_seen = !sda_s;
        end
        if (lose)
        begin
          // Data register shifts in the bus bit that beat us on this same edge
          next_drive = '0;
          next_master = 1'b0;
          next_bit_cnt = bit_cnt + 1'b1;
          next_state = S_SLAVE_RX;
          if (bit_cnt == twowire_pkg::BITS_PER_BYTE - 1'b1)
          begin
            next_status = twowire_pkg::ST_ARB_LOST;
            report = 1'b1;
            next_bit_cnt = '0;
            next_state = S_IDLE;
          end
        end
        else if (high_done && bit_cnt == twowire_pkg::BITS_PER_BYTE)
        begin
          next_drive.scl_oe = 1'b1;
          next_status = byte_code;
          report = 1'b1;
          next_first_byte = 1'b0;
          if (first_byte)
          begin
            next_rx_dir = sh_q[0];
          end
          next_bit_cnt = '0;
          next_state = S_SUSPEND;
        end
        else if (high_done)
        begin
          next_bit_cnt = bit_cnt + 1'b1;
          next_state = S_BIT_LOW;
        end
      end
      S_SUSPEND:
      begin
        next_drive.scl_oe = 1'b1;
        if (!ctrl.serial_irq_flag)
        begin
          next_drive.sda_oe = 1'b0;
          if (ctrl.stop_request_flag)
          begin
            next_state = S_STOP_LOW;
          end
          else if (ctrl.start_request_flag)
          begin
            next_state = S_RESTART_LOW;
          end
          else
          begin
            next_state = S_BIT_LOW;
          end
        end
      end
      S_STOP_LOW:
      begin
        next_drive = 2'b11;
        if (low_done)
        begin
          next_state = S_STOP_HIGH;
        end
      end
      S_STOP_HIGH:
      begin
        next_drive = 2'b01;
        if (high_done)
        begin
          next_drive = '0;
          next_master = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_RESTART_LOW:
      begin
        next_drive = 2'b10;
        if (low_done)
        begin
          next_state = S_RESTART_HIGH;
        end
      end
      S_RESTART_HIGH:
      begin
        next_drive = '0;
        if (high_done)
        begin
          next_drive.sda_oe = 1'b1;
          next_state = S_START_HOLD;
        end
      end
      S_SLAVE_RX:
      begin
        next_drive = '0;
        if (scl_rise)
        begin
          sh_shift = 1'b1;
          next_bit_cnt = bit_cnt + 1'b1;
          if (bit_cnt == twowire_pkg::BITS_PER_BYTE - 1'b1)
          begin
            next_status = twowire_pkg::ST_ARB_LOST;
            report = 1'b1;
            next_bit_cnt = '0;
            next_state = S_IDLE;
          end
        end
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase

    // Software write of the control flags; busy is read only
    if (ctrl_wr)
    begin
      next_ctrl = wr_flags;
      next_ctrl.busy = ctrl.busy;
    end
    // Bus activity tracking
    if (start_seen)
    begin
      next_ctrl.busy = 1'b1;
    end
    if (stop_seen || free_timeout)
    begin
      next_ctrl.busy = 1'b0;
      if (state == S_SLAVE_RX)
      begin
        next_state = S_IDLE;
        next_bit_cnt = '0;
      end
    end
    // Detected STOP, or the simulated one in slave mode, clears the stop flag
    if (!ctrl_wr && (stop_seen || (ctrl.stop_request_flag && !master && state == S_IDLE)))
    begin
      next_ctrl.stop_request_flag = 1'b0;
    end
    // External slave states also report; idle code is never flagged
    if (ext_state_valid && ext_state_code != twowire_pkg::ST_IDLE)
    begin
      next_status = ext_state_code;
    end
    // Hardware set wins over a software clear; a repeated code still raises it
    if (report || (ext_state_valid && ext_state_code != twowire_pkg::ST_IDLE))
    begin
      next_ctrl.serial_irq_flag = 1'b1;
    end
    // Disabling drops the interface off the bus and forgets bus state
    if (!ctrl.enable)
    begin
      next_state = S_IDLE;
      next_drive = '0;
      next_master = 1'b0;
      next_bit_cnt = '0;
      next_ctrl.busy = 1'b0;
    end
    next_timer_reload = ctrl.low_timeout_enable && scl_s;
    next_timer_count = ctrl.low_timeout_enable && !scl_s;
  end

  // Register everything computed above
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      ctrl <= twowire_pkg::CTRL_RESET;
      rate <= twowire_pkg::RATE_RESET;
      status_code <= twowire_pkg::ST_IDLE;
      drive <= '0;
      bit_cnt <= '0;
      pad_cnt <= '0;
      pad_run <= 1'b0;
      master <= 1'b0;
      first_byte <= 1'b0;
      rx_dir <= 1'b0;
      ack_seen <= 1'b0;
      free_cnt <= '0;
      timer_reload <= 1'b0;
      timer_count <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ctrl <= next_ctrl;
      rate <= next_rate;
      status_code <= next_status;
      drive <= next_drive;
      bit_cnt <= next_bit_cnt;
      pad_cnt <= next_pad_cnt;
      pad_run <= next_pad_run;
      master <= next_master;
      first_byte <= next_first_byte;
      rx_dir <= next_rx_dir;
      ack_seen <= next_ack_seen;
      free_cnt <= next_free_cnt;
      timer_reload <= next_timer_reload;
      timer_count <= next_timer_count;
    end
  end
endmodule

// ### bench/twowire_slave_model.sv
// Behavioural bus slave that acknowledges and drives bytes on request
`timescale 1ns/1ps
module twowire_slave_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic drive_en,
  input wire logic [7:0] tx_byte,
  output logic pull
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int cnt = 0;
  // Slot count moves on each SCL fall; START or STOP restarts it
  always @(posedge clk)
  begin
    if (scl && scl_q && sda != sda_q)
      cnt <= 0;
    else if (scl_q && !scl)
      cnt <= (cnt == 9) ? 1 : cnt + 1;
    scl_q <= scl;
    sda_q <= sda;
  end
  // Live controls, so changes made during a stall still apply
  always_comb
  begin
    if (cnt == 0)
      pull = 1'b0;
    else if (cnt == 9)
      pull = ack_en;
    else
      pull = drive_en & ~tx_byte[8 - cnt];
  end
endmodule

// ### bench/twowire_bus_ctrl_rate_data_checker.sv
// Port assertions for the two-wire control, rate and data block
`timescale 1ns/1ps
module twowire_bus_ctrl_rate_data_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic rate_wr,
  input wire logic [7:0] rate_wdata,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [7:0] rate_rdata,
  input wire logic [7:0] data_rdata,
  input wire logic [7:0] status_code,
  input wire logic ext_state_valid,
  input wire logic [7:0] ext_state_code,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic timer_reload,
  input wire logic timer_count
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [8:0] lo_cnt;
  logic [8:0] next_lo_cnt;
  // Unstalled SCL low time; a stall restarts it so suspension is not counted
  always_comb
  begin
    next_lo_cnt = (scl_oe && !ctrl_rdata[3]) ? lo_cnt + 9'h001 : 9'h000;
  end
  always_ff @(posedge clk)
  begin
    lo_cnt <= rst_n ? next_lo_cnt : 9'h000;
  end
  a_irq_sticky: assert property (ctrl_rdata[3] && !ctrl_wr |=> ctrl_rdata[3])
    else $error("interrupt flag dropped without a write");
  a_irq_cause: assert property ($rose(ctrl_rdata[3]) && !$past(ctrl_wr) |->
    status_code != 8'hf8 && status_code[2:0] == 3'h0)
    else $error("interrupt flag rose without a new state");
  a_irq_event: assert property (ext_state_valid && ext_state_code != 8'hf8 &&
    ext_state_code != status_code |=> ctrl_rdata[3] && status_code == $past(ext_state_code))
    else $error("reported state did not raise the flag");
  a_idle_quiet: assert property (ext_state_valid && ext_state_code == 8'hf8 &&
    !ctrl_rdata[3] && !ctrl_wr && !scl_oe && !sda_oe |=> !ctrl_rdata[3])
    else $error("idle code raised the flag");
  a_stall_low: assert property (ctrl_rdata[3] && scl_oe && !ctrl_wr |=> scl_oe)
    else $error("clock released while flag set");
  a_low_time: assert property (lo_cnt <= 9'h102 - {1'b0, rate_rdata})
    else $error("clock low phase too long");
  a_stop_clear: assert property ((scl_in && !sda_in) ##1
    (scl_in && sda_in && !ctrl_wr) [*5] |-> !ctrl_rdata[4])
    else $error("stop flag kept after bus stop");
  a_start_go: assert property (ctrl_rdata[6] && ctrl_rdata[5] && !ctrl_rdata[7] &&
    !ctrl_rdata[3] && !scl_oe && !sda_oe |-> ##[1:3] sda_oe)
    else $error("start not issued on free bus");
  a_tmr_reload: assert property ((ctrl_rdata[0] && scl_in) [*4] |->
    timer_reload && !timer_count)
    else $error("timer not reloading while clock high");
  a_tmr_count: assert property ((ctrl_rdata[0] && !scl_in) [*4] |->
    timer_count && !timer_reload)
    else $error("timer not counting while clock low");
  c_start: cover property (status_code == 8'h08 && ctrl_rdata[3]);
  c_rx_ack: cover property (status_code == 8'h50 && ctrl_rdata[3]);
  c_arb: cover property (status_code == 8'h38 && ctrl_rdata[3]);
endmodule
bind twowire_bus_ctrl_rate_data twowire_bus_ctrl_rate_data_checker u_checker (
  .clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .rate_wr(rate_wr),
  .rate_wdata(rate_wdata), .data_wr(data_wr), .data_wdata(data_wdata),
  .ctrl_rdata(ctrl_rdata), .rate_rdata(rate_rdata), .data_rdata(data_rdata),
  .status_code(status_code), .ext_state_valid(ext_state_valid),
  .ext_state_code(ext_state_code), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .timer_reload(timer_reload),
  .timer_count(timer_count)
);

// ### bench/test_twowire_bus_ctrl_rate_data.sv
// Self-checking bench for the two-wire control, rate and data block
`timescale 1ns/1ps
module test_twowire_bus_ctrl_rate_data;
  localparam logic [7:0] CV = 8'h47; // Enabled, acknowledge, both timeouts
  localparam logic [7:0] RATE = 8'hb0; // Under the rate bound at 100 MHz
  localparam int LO = 80;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ctrl_wr = 1'b0;
  logic rate_wr = 1'b0;
  logic data_wr = 1'b0;
  logic ext_state_valid = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] ext_state_code = 8'h00;
  logic [7:0] ctrl_rdata, rate_rdata, data_rdata, status_code;
  logic scl_out, scl_oe, sda_out, sda_oe, timer_reload, timer_count, pull;
  logic scl_q = 1'b1;
  logic oe_q = 1'b0;
  logic ack_en = 1'b0;
  logic drive_en = 1'b0;
  logic scl_hold = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [8:0] bus_sh = 9'h000;
  wire scl = ~(scl_oe | scl_hold);
  wire sda = ~(sda_oe | pull);
  int run = 0, lo_len = 0, hi_len = 0, n_mismatch = 0, compares = 0, n = 0;
  always #5 clk = ~clk;
  twowire_bus_ctrl_rate_data u_twowire_bus_ctrl_rate_data (
    .clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(wdata), .rate_wr(rate_wr),
    .rate_wdata(wdata), .data_wr(data_wr), .data_wdata(wdata), .ctrl_rdata(ctrl_rdata),
    .rate_rdata(rate_rdata), .data_rdata(data_rdata), .status_code(status_code),
    .ext_state_valid(ext_state_valid), .ext_state_code(ext_state_code), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .timer_reload(timer_reload), .timer_count(timer_count)
  );
  twowire_slave_model u_twowire_slave_model (
    .clk(clk), .scl(scl), .sda(sda), .ack_en(ack_en), .drive_en(drive_en),
    .tx_byte(tx_byte), .pull(pull)
  );
  // Bits on the wire and lengths of the driven low and released high phases
  always @(posedge clk)
  begin
    scl_q <= scl;
    oe_q <= scl_oe;
    if (scl && !scl_q)
      bus_sh <= {bus_sh[7:0], sda};
    if (scl_oe != oe_q)
      run <= 1;
    else
      run <= run + 1;
    if (oe_q && !scl_oe)
      lo_len <= run;
    if (!oe_q && scl_oe)
      hi_len <= run;
  end
  task automatic end_sim();
  begin
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task automatic tick();
  begin
    @(posedge clk);
    #1;
  end
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
  begin
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] v);
  begin
    wdata = v;
    ctrl_wr = (sel == 2'h0);
    rate_wr = (sel == 2'h1);
    data_wr = (sel == 2'h2);
    tick();
    ctrl_wr = 1'b0;
    rate_wr = 1'b0;
    data_wr = 1'b0;
    tick();
  end
  endtask
  task automatic ev(input logic [7:0] code);
  begin
    ext_state_code = code;
    ext_state_valid = 1'b1;
    tick();
    ext_state_valid = 1'b0;
    tick();
  end
  endtask
  // Bounded wait: 0 flag set, 1 stop flag clear, 2 data line driven
  task automatic wait_for(input logic [1:0] what);
  begin
    n = 0;
    while (!(what == 2'h0 ? ctrl_rdata[3] === 1'b1 :
        what == 2'h1 ? ctrl_rdata[4] === 1'b0 : sda_oe === 1'b1))
    begin
      tick();
      n++;
      if (n > 30000)
      begin
        n_mismatch++;
        $display("mismatch wait %0d expected done seen hang", what);
        end_sim();
      end
    end
  end
  endtask
  // Release the stall with cv, then check the reported state and the byte
  task automatic step(input logic [7:0] cv, input logic [8:0] bus, input logic [7:0] st,
      input logic full);
  begin
    wr(2'h0, cv);
    wait_for(2'h0);
    tick();
    chk("status", status_code, st);
    if (full)
    begin
      chk("bus bits", 16'(bus_sh), 16'(bus));
      chk("data", data_rdata, bus[8:1]);
      chk("low time", 16'(lo_len), 16'(LO));
      chk("high time", 16'(hi_len >= LO + 62 && hi_len <= LO + 68), 16'h0001);
    end
  end
  endtask
  initial
  begin
    repeat (10) tick();
    rst_n = 1'b1;
    tick();
    chk("reset", {ctrl_rdata, rate_rdata}, 16'h0000);
    chk("reset", {data_rdata, status_code}, 16'h00f8);
    wr(2'h0, 8'h80);
    chk("busy read only", ctrl_rdata, 8'h00);
    ev(8'hf8);
    chk("idle flag", ctrl_rdata[3], 16'h0000);
    ev(8'h50);
    chk("event flag", {ctrl_rdata, status_code}, 16'h0850);
    wr(2'h0, 8'h00);
    chk("flag clear", ctrl_rdata, 8'h00);
    wr(2'h1, RATE);
    chk("rate", rate_rdata, RATE);
    $display("test registers done");
    ack_en = 1'b1;
    step(CV | 8'h20, 9'h000, 8'h08, 1'b0);
    wr(2'h2, 8'ha4);
    step(CV, {8'ha4, 1'b0}, 8'h18, 1'b1);
    wr(2'h2, 8'h6e);
    step(CV, {8'h6e, 1'b0}, 8'h28, 1'b1);
    wr(2'h2, 8'h6e);
    step(CV, {8'h6e, 1'b0}, 8'h28, 1'b1);
    ack_en = 1'b0;
    wr(2'h2, 8'h5b);
    step(CV, {8'h5b, 1'b1}, 8'h30, 1'b1);
    ack_en = 1'b1;
    step(CV | 8'h20, 9'h000, 8'h10, 1'b0);
    wr(2'h2, 8'ha5);
    step(CV, {8'ha5, 1'b0}, 8'h40, 1'b1);
    ack_en = 1'b0;
    drive_en = 1'b1;
    tx_byte = 8'hc3;
    step(CV, {8'hc3, 1'b0}, 8'h50, 1'b1);
    tx_byte = 8'h3c;
    step(CV & 8'hfb, {8'h3c, 1'b1}, 8'h58, 1'b1);
    drive_en = 1'b0;
    wr(2'h0, CV | 8'h10);
    wait_for(2'h1);
    tick();
    tick();
    chk("after stop", {ctrl_rdata[7], scl_oe, sda_oe}, 16'h0000);
    $display("test master transfer done");
    step(CV | 8'h20, 9'h000, 8'h08, 1'b0);
    wr(2'h2, 8'h81);
    drive_en = 1'b1;
    tx_byte = 8'h80;
    step(CV, 9'h000, 8'h38, 1'b0);
    chk("arb data", data_rdata, 8'h80);
    chk("arb lines", {scl_oe, sda_oe}, 16'h0000);
    $display("test arbitration done");
    scl_hold = 1'b1;
    tick();
    drive_en = 1'b0;
    tick();
    scl_hold = 1'b0;
    wr(2'h0, CV | 8'h20);
    wait_for(2'h2);
    chk("free wait", 16'(n >= 795 && n <= 812), 16'h0001);
    wait_for(2'h0);
    tick();
    chk("start", status_code, 8'h08);
    wr(2'h0, CV | 8'h10);
    wait_for(2'h1);
    $display("test free timeout done");
    end_sim();
  end
endmodule
